// *** design/ftc_pkg.sv ***
// shared constants and types of the frequency translation control block
package ftc_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BW = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_INT0 = 8'h10;
    localparam logic [7:0] OFF_FRAC_N0 = 8'h30;
    localparam logic [7:0] OFF_FRAC_F0 = 8'h38;
    // ------------------------------------------------------------
    // control fields and codes
    // ------------------------------------------------------------
    localparam int CTRL_SYNTH = 0;
    localparam int CTRL_STATE = 1;
    localparam int CTRL_ACQ = 3;
    localparam int CTRL_POLICY = 4;
    localparam int CTRL_SLOPE = 5;
    localparam int CTRL_LOOPBACK = 7;
    localparam logic [1:0] STATE_FREERUN = 2'h1;
    localparam int BW_LOCK = 0;
    localparam int BW_ACQ = 4;
    localparam logic [3:0] BW_MAX = 4'h8;
    localparam logic [3:0] BW_SYNTH = 4'h9;
    localparam logic [2:0] SRC_PLL = 3'h0;
    localparam logic [2:0] SRC_XTAL = 3'h5;
    localparam int INT_S1 = 0;
    localparam int INT_SRC = 4;
    localparam int INT_HALF = 16;
    localparam int NUM_INT = 6;
    // ------------------------------------------------------------
    // reset values, fractional N limits and response codes
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] BW_RST = 32'h0000_0000;
    localparam logic [31:0] INT_RST = 32'h0000_0000;
    localparam logic [17:0] FRAC_N_RST = 18'h00004;
    localparam logic [17:0] FRAC_N_MIN = 18'h00004;
    localparam logic [17:0] FRAC_N_INT = 18'h00003;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [15:0] half;
        logic [2:0] src;
        logic [1:0] s1;
    } ftc_int_cfg_type;

    typedef struct packed {
        logic [17:0] n;
        logic [27:0] f;
    } ftc_frac_cfg_type;

    typedef struct packed {
        logic rise;
        logic lvl;
        logic [2:0] c1;
        logic [15:0] c2;
    } ftc_int_st_type;

    typedef struct packed {
        logic rise;
        logic lvl;
        logic [18:0] cnt;
        logic [18:0] len;
        logic [27:0] acc;
    } ftc_frac_st_type;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_SLEW = 2'b10
    } ftc_phase_type;
endpackage : ftc_pkg

// *** design/ftc_core.sv ***
// frequency translation control: bandwidth, output dividers, switchover phase
// Function
// - synth-only with free-run state runs from crystal, needs no reference
// - synthesizer-only operation in free-run state forces the fixed wide loop bandwidth
// - otherwise bandwidth is one of nine doubling steps, 1.40625 Hz to 360 Hz
// - acquisition choice used until lock when enabled, then locked choice
// - acquisition disabled means locked choice always applies
// - eight output dividers, six integer and two fractional
// - integer divider is two cascaded stages, first divides by 4, 5 or 6
// - second stage bypassed or any even ratio 2 to 131,070
// - flexible outputs may bypass first stage for non-PLL sources
// - fractional divider divides by 2 x N.F, N 4 to 2^18-1, 28-bit F
// - fractional N of three allowed only with zero fraction
// - first four outputs always clocked from the PLL
// - flexible dividers pick PLL, a fractional output, a reference or crystal
// - switchover and holdover edges use slope limiting or hitless per policy bit
// - hitless policy keeps output phase unchanged across those events
// - slope limiting moves phase toward new condition at programmed rate
// - path delay may step once on switchover, holdover edge or reconfiguration
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module ftc_core
    import ftc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ref_input_a,
    input wire logic ref_input_b,
    input wire logic crystal_in,
    input wire logic pll_locked,
    input wire logic holdover_active,
    input wire logic active_ref,
    input wire logic phase_settled,
    output logic [7:0] out_clk,
    output logic [3:0] loop_bw_sel,
    output logic ref_required,
    output logic phase_hold,
    output logic slew_active,
    output logic [1:0] slew_rate,
    output logic static_path_delay
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] ftc_merge(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction : ftc_merge

    function automatic logic [3:0] ftc_bw_clamp(input logic [3:0] c);
        return (c > BW_MAX) ? BW_MAX : c;
    endfunction : ftc_bw_clamp

    function automatic logic [2:0] ftc_s1_ratio(input logic [1:0] sel, input logic byp_ok);
        unique case (sel)
            2'h0: return 3'h4;
            2'h1: return 3'h5;
            2'h2: return 3'h6;
            default: return byp_ok ? 3'h1 : 3'h4;
        endcase
    endfunction : ftc_s1_ratio

    function automatic ftc_int_st_type ftc_int_step(input ftc_int_st_type s,
        input ftc_int_cfg_type c, input logic flex);
        ftc_int_st_type n;
        logic [2:0] d1;
        logic p1;
        n = s;
        d1 = ftc_s1_ratio(c.s1, flex && (c.src != SRC_PLL));
        p1 = (s.c1 == d1 - 3'h1);
        n.c1 = p1 ? 3'h0 : s.c1 + 3'h1;
        if (c.half == 16'h0) begin
            n.lvl = (d1 == 3'h1) ? ~s.lvl : (n.c1 < (d1 >> 1));
        end else if (p1) begin
            // toggles every half pulses: even ratio
            if (s.c2 == c.half - 16'h1) begin
                n.c2 = 16'h0;
                n.lvl = ~s.lvl;
            end else begin
                n.c2 = s.c2 + 16'h1;
            end
        end
        n.rise = n.lvl & ~s.lvl;
        return n;
    endfunction : ftc_int_step

    function automatic ftc_frac_st_type ftc_frac_step(input ftc_frac_st_type s,
        input ftc_frac_cfg_type c);
        ftc_frac_st_type n;
        logic [28:0] sum;
        n = s;
        sum = {1'b0, s.acc} + {1'b0, c.f};
        if (s.cnt >= s.len - 19'h1) begin
            n.cnt = 19'h0;
            n.lvl = ~s.lvl;
            n.acc = sum[27:0];
            n.len = {1'b0, c.n} + {18'h0, sum[28]};
        end else begin
            n.cnt = s.cnt + 19'h1;
        end
        n.rise = n.lvl & ~s.lvl;
        return n;
    endfunction : ftc_frac_step

    function automatic logic ftc_frac_ok(input ftc_frac_cfg_type c);
        return (c.n >= FRAC_N_MIN) || (c.n == FRAC_N_INT && c.f == 28'h0);
    endfunction : ftc_frac_ok

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [6:0] pin_raw;
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] sync3;
    logic [6:0] filt;
    logic [6:0] filt_d;
    assign pin_raw = {phase_settled, active_ref, holdover_active, pll_locked,
                      crystal_in, ref_input_b, ref_input_a};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 7'h00;
            sync2 <= 7'h00;
            sync3 <= 7'h00;
            filt <= 7'h00;
            filt_d <= 7'h00;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            // a change counts once the last two stages agree
            filt <= (sync3 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
            filt_d <= filt;
        end
    end

    // ------------------------------------------------------------
    // register file and axi4-lite slave
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] bw;
    logic [31:0] int_reg [NUM_INT];
    logic [31:0] frac_n_reg [2];
    logic [31:0] frac_f_reg [2];
    logic [31:0] status;
    logic wr_go;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_val;
    logic cfg_write;
    ftc_frac_cfg_type frac_cfg [2];
    logic frac_err [2];

    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = s_axi_awready;

    always_comb begin
        unique case (s_axi_awaddr[7:2])
            OFF_CTRL[7:2], OFF_BW[7:2]: wr_hit = 1'b1;
            default: wr_hit = (s_axi_awaddr >= OFF_INT0 && s_axi_awaddr < OFF_INT0 + 8'h18) ||
                              (s_axi_awaddr >= OFF_FRAC_N0 && s_axi_awaddr < OFF_FRAC_N0 + 8'h10);
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RST;
            bw <= BW_RST;
            for (int i = 0; i < NUM_INT; i++) begin
                int_reg[i] <= INT_RST;
            end
            for (int i = 0; i < 2; i++) begin
                frac_n_reg[i] <= {14'h0, FRAC_N_RST};
                frac_f_reg[i] <= 32'h0000_0000;
            end
        end else if (wr_go && wr_hit) begin
            if (s_axi_awaddr[7:2] == OFF_CTRL[7:2]) begin
                ctrl <= ftc_merge(ctrl, s_axi_wdata, s_axi_wstrb) & 32'h0000_00ff;
            end
            if (s_axi_awaddr[7:2] == OFF_BW[7:2]) begin
                bw <= ftc_merge(bw, s_axi_wdata, s_axi_wstrb) & 32'h0000_00ff;
            end
            for (int i = 0; i < NUM_INT; i++) begin
                if (s_axi_awaddr[7:2] == OFF_INT0[7:2] + 6'(i)) begin
                    int_reg[i] <= ftc_merge(int_reg[i], s_axi_wdata, s_axi_wstrb) &
                                  32'hffff_0073;
                end
            end
            for (int i = 0; i < 2; i++) begin
                if (s_axi_awaddr[7:2] == OFF_FRAC_N0[7:2] + 6'(i)) begin
                    frac_n_reg[i] <= ftc_merge(frac_n_reg[i], s_axi_wdata, s_axi_wstrb) &
                                     32'h0003_ffff;
                end
                if (s_axi_awaddr[7:2] == OFF_FRAC_F0[7:2] + 6'(i)) begin
                    frac_f_reg[i] <= ftc_merge(frac_f_reg[i], s_axi_wdata, s_axi_wstrb) &
                                     32'h0fff_ffff;
                end
            end
        end
    end

    assign cfg_write = wr_go && wr_hit && (s_axi_awaddr >= OFF_INT0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        if (s_axi_araddr[7:2] == OFF_CTRL[7:2]) begin
            rd_val = ctrl;
        end else if (s_axi_araddr[7:2] == OFF_BW[7:2]) begin
            rd_val = bw;
        end else if (s_axi_araddr[7:2] == OFF_STATUS[7:2]) begin
            rd_val = status;
        end else if (s_axi_araddr >= OFF_INT0 && s_axi_araddr < OFF_INT0 + 8'h18) begin
            rd_val = int_reg[3'(s_axi_araddr[7:2] - OFF_INT0[7:2])];
        end else if (s_axi_araddr >= OFF_FRAC_N0 && s_axi_araddr < OFF_FRAC_F0) begin
            rd_val = frac_n_reg[s_axi_araddr[2]];
        end else if (s_axi_araddr >= OFF_FRAC_F0 && s_axi_araddr < OFF_FRAC_F0 + 8'h08) begin
            rd_val = frac_f_reg[s_axi_araddr[2]];
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // operating mode and loop bandwidth
    // ------------------------------------------------------------
    logic synth_active;
    logic [3:0] next_bw;
    assign synth_active = ctrl[CTRL_SYNTH] && (ctrl[CTRL_STATE +: 2] == STATE_FREERUN);

    always_comb begin
        if (synth_active) begin
            next_bw = BW_SYNTH;
        end else if (ctrl[CTRL_ACQ] && !filt[3]) begin
            next_bw = ftc_bw_clamp(bw[BW_ACQ +: 4]);
        end else begin
            next_bw = ftc_bw_clamp(bw[BW_LOCK +: 4]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_bw_sel <= BW_MAX;
            ref_required <= 1'b1;
        end else begin
            loop_bw_sel <= next_bw;
            ref_required <= !synth_active;
        end
    end

    // ------------------------------------------------------------
    // fractional dividers, always fed by the pll
    // ------------------------------------------------------------
    ftc_frac_cfg_type frac_act [2];
    ftc_frac_st_type frac_st [2];
    ftc_frac_st_type next_frac [2];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            frac_cfg[i] = '{n: frac_n_reg[i][17:0], f: frac_f_reg[i][27:0]};
            frac_err[i] = !ftc_frac_ok(frac_cfg[i]);
            next_frac[i] = ftc_frac_step(frac_st[i], frac_act[i]);
        end
    end

    // a rejected setting is kept off the divider; the old ratio keeps running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 2; i++) begin
                frac_act[i] <= '{n: FRAC_N_RST, f: 28'h0};
                frac_st[i] <= '{rise: 1'b0, lvl: 1'b0, cnt: 19'h0,
                                len: {1'b0, FRAC_N_RST}, acc: 28'h0};
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                frac_st[i] <= next_frac[i];
                if (next_frac[i].rise && !frac_err[i]) begin
                    frac_act[i] <= frac_cfg[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // integer dividers
    // ------------------------------------------------------------
    logic [5:0] ticks;
    ftc_int_cfg_type int_act [NUM_INT];
    ftc_int_st_type int_st [NUM_INT];
    ftc_int_st_type next_int [NUM_INT];
    logic [NUM_INT-1:0] int_tick;

    // source index: pll, fractional a, fractional b, reference a, reference b, crystal
    assign ticks = {filt[2] & ~filt_d[2], filt[1] & ~filt_d[1], filt[0] & ~filt_d[0],
                    frac_st[1].rise, frac_st[0].rise, 1'b1};

    always_comb begin
        for (int i = 0; i < NUM_INT; i++) begin
            // only the four flexible dividers may leave the pll
            int_tick[i] = (i < 2 || int_act[i].src > SRC_XTAL) ? 1'b1
                          : ticks[int_act[i].src];
            next_int[i] = int_tick[i] ? ftc_int_step(int_st[i], int_act[i], i >= 2) :
                ftc_int_st_type'{rise: 1'b0, lvl: int_st[i].lvl,
                    c1: int_st[i].c1, c2: int_st[i].c2};
        end
    end

    // a stalled source also stalls the pending ratio update until it runs again
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_INT; i++) begin
                int_act[i] <= ftc_int_cfg_type'(INT_RST[20:0]);
                int_st[i] <= '{rise: 1'b0, lvl: 1'b0, c1: 3'h0, c2: 16'h0};
            end
        end else begin
            for (int i = 0; i < NUM_INT; i++) begin
                int_st[i] <= next_int[i];
                if (next_int[i].rise) begin
                    int_act[i] <= '{half: int_reg[i][INT_HALF +: 16],
                                    src: int_reg[i][INT_SRC +: 3],
                                    s1: int_reg[i][INT_S1 +: 2]};
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_clk <= 8'h00;
        end else begin
            out_clk <= {next_int[5].lvl, next_int[4].lvl, next_int[3].lvl, next_int[2].lvl,
                        next_frac[1].lvl, next_frac[0].lvl,
                        next_int[1].lvl, next_int[0].lvl};
        end
    end

    // ------------------------------------------------------------
    // output phase policy on switchover and holdover
    // ------------------------------------------------------------
    ftc_phase_type ph_state;
    ftc_phase_type next_ph;
    logic ph_event;
    logic hitless;
    assign ph_event = (filt[4] ^ filt_d[4]) | (filt[5] ^ filt_d[5]);
    assign hitless = ctrl[CTRL_POLICY];

    always_comb begin
        next_ph = ph_state;
        unique case (ph_state)
            PH_IDLE: begin
                if (ph_event && !hitless) begin
                    next_ph = PH_SLEW;
                end
            end
            PH_SLEW: begin
                // a fresh slope-limited event while slewing wins over settling
                if (filt[6] && !(ph_event && !hitless)) begin
                    next_ph = PH_IDLE;
                end
            end
            default: next_ph = PH_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph_state <= PH_IDLE;
            phase_hold <= 1'b0;
            slew_active <= 1'b0;
            slew_rate <= 2'h0;
            static_path_delay <= 1'b0;
        end else begin
            ph_state <= next_ph;
            phase_hold <= ph_event && hitless;
            slew_active <= (next_ph == PH_SLEW);
            slew_rate <= ctrl[CTRL_SLOPE +: 2];
            static_path_delay <= ph_event || cfg_write;
        end
    end

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    assign status = {20'h0, loop_bw_sel, 1'b0, frac_err[1], frac_err[0],
                     hitless && ctrl[CTRL_LOOPBACK],
                     slew_active, filt[4], filt[3], synth_active};
endmodule : ftc_core

// *** tb/ftc_asserts.sv ***
// bound assertion checker for the frequency translation control block
`timescale 1ns/1ps
module ftc_asserts
    import ftc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [3:0] loop_bw_sel,
    input wire logic ref_required,
    input wire logic phase_hold,
    input wire logic [1:0] slew_rate
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid; endsequence
    // entry may lag by a cycle, so demand two low samples
    sequence s_synth; !ref_required [*2]; endsequence
    property p_bw_range; loop_bw_sel <= BW_SYNTH; endproperty
    property p_synth_bw; s_synth |-> loop_bw_sel == BW_SYNTH; endproperty
    property p_hold_pulse; phase_hold |=> !phase_hold; endproperty
    property p_slew_rate;
        s_wr ##0 s_axi_awaddr == OFF_CTRL |-> ##2 slew_rate == $past(s_axi_wdata[6:5], 2);
    endproperty
    property p_wr_answer; s_wr |=> s_axi_bvalid; endproperty
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_bad_wr; s_wr ##0 s_axi_awaddr == OFF_STATUS |=> s_axi_bresp == RESP_SLVERR;
    endproperty
    a_bw_range: assert property (p_bw_range) else $error("bw code out of range");
    a_synth_bw: assert property (p_synth_bw) else $error("synth bw not wide");
    a_hold_pulse: assert property (p_hold_pulse) else $error("hold pulse too long");
    a_slew_rate: assert property (p_slew_rate) else $error("slope rate not taken");
    a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_bad_wr: assert property (p_bad_wr) else $error("status write accepted");
endmodule : ftc_asserts

bind ftc_core ftc_asserts u_chk (.*);

// *** tb/ftc_partner.sv ***
// reference clock and crystal sources seen by the frequency translation block
`timescale 1ns/1ps
module ftc_partner (
    input wire logic refs_on,
    output logic ref_a,
    output logic ref_b,
    output logic xtal
);
    logic base = 1'b0;
    int ca = 0;
    int cb = 0;
    initial xtal = 1'b0;
    initial #1.3 forever #2 base = ~base;
    always #20 xtal = ~xtal;
    // both references come from one base clock: one clock domain
    always @(posedge base) begin
        ca <= (ca == 5) ? 0 : ca + 1;
        cb <= (cb == 7) ? 0 : cb + 1;
        ref_a <= refs_on && ca < 3;
        ref_b <= refs_on && cb < 4;
    end
endmodule : ftc_partner

// *** tb/testbench.sv ***
// self-checking bench for the frequency translation control block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("mismatch at %0t: got %0h want %0h", $time, a, b); end end
module testbench
    import ftc_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ref_input_a, ref_input_b, crystal_in, pll_locked, refs_on;
    logic holdover_active, active_ref, phase_settled, ref_required, phase_hold;
    logic slew_active, static_path_delay;
    logic [7:0] s_axi_awaddr, s_axi_araddr, out_clk, oc_q;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, loop_bw_sel;
    logic [1:0] s_axi_bresp, s_axi_rresp, slew_rate;
    logic [1:0] wq[$];
    logic [33:0] rq[$];
    int failures, total_checks, seed, k, s, h;
    ftc_core DUT (.*);
    ftc_partner PM (.refs_on(refs_on), .ref_a(ref_input_a), .ref_b(ref_input_b),
        .xtal(crystal_in));
    always #2 aclk = ~aclk;
    // ----------------------------------------
    // response monitor and bus tasks
    // ----------------------------------------
    always @(posedge aclk) begin
        oc_q <= out_clk;
        if (s_axi_bvalid && s_axi_bready) `CHK(s_axi_bresp, wq.pop_front())
        if (s_axi_rvalid && s_axi_rready) `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic tmo(input bit t);
        if (t) failures++;
        if (t) summarize();
    endtask : tmo
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        wq.push_back(r);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
        do @(negedge aclk); while (!s_axi_awready && n++ < 200);
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
        repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(negedge aclk); while (!s_axi_bvalid && n++ < 200);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        tmo(n >= 200);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        rq.push_back({r, d});
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do @(negedge aclk); while (!s_axi_arready && n++ < 200);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid && n++ < 200);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        tmo(n >= 200);
    endtask : rd
    // cycles of np periods after two settling rises
    task automatic per(input int b, input int np, input int e);
        int n = 0, c = 0;
        for (int i = 0; i < np + 2; i++) begin
            if (i == 2) c = 0;
            do begin
                @(posedge aclk);
                c++;
            end while (!(out_clk[b] && !oc_q[b]) && n++ < 3000);
        end
        `CHK(c, e)
        tmo(n >= 3000);
    endtask : per
    task automatic evt(input int eh, input int es);
        int ph = 0, sa = 0, sp = 0;
        repeat (16) begin
            @(posedge aclk);
            ph += phase_hold;
            sa |= slew_active;
            sp += static_path_delay;
        end
        `CHK(ph, eh)
        `CHK(sa, es)
        `CHK(sp, 1)
    endtask : evt
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
        {s_axi_rready, pll_locked, holdover_active, active_ref, phase_settled} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, failures, total_checks} = 0;
        s_axi_wstrb = 4'hf;
        refs_on = 1'b1;
        seed = 32'h6917;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFF_FRAC_N0, 32'h4, RESP_OKAY);
        rd(8'hf0, 32'h0, RESP_SLVERR);
        wr(OFF_STATUS, 32'hffff_ffff, RESP_SLVERR);
        for (k = 0; k < 10; k++) begin
            wr(OFF_BW, k, RESP_OKAY);
            repeat (2) @(posedge aclk);
            `CHK(loop_bw_sel, (k > 8) ? BW_MAX : 4'(k))
        end
        wr(OFF_BW, 32'h62, RESP_OKAY);
        wr(OFF_CTRL, 32'h8, RESP_OKAY);
        repeat (8) @(posedge aclk);
        `CHK(loop_bw_sel, 4'h6)
        pll_locked <= 1'b1;
        repeat (8) @(posedge aclk);
        `CHK(loop_bw_sel, 4'h2)
        pll_locked <= 1'b0;
        wr(OFF_CTRL, 32'h0, RESP_OKAY);
        repeat (8) @(posedge aclk);
        `CHK(loop_bw_sel, 4'h2)
        $display("bandwidth test done");
        wr(OFF_CTRL, 32'h3, RESP_OKAY);
        refs_on <= 1'b0;
        repeat (2) @(posedge aclk);
        `CHK({ref_required, loop_bw_sel}, {1'b0, BW_SYNTH})
        wr(OFF_INT0 + 8'h8, 32'h1_0053, RESP_OKAY);
        per(4, 2, 40);
        wr(OFF_CTRL, 32'h0, RESP_OKAY);
        refs_on <= 1'b1;
        for (k = 0; k < 4; k++) begin
            s = (k == 0) ? 0 : k + 2;
            wr(OFF_INT0 + 8'h8, 32'h1_0003 | (s << 4), RESP_OKAY);
            per(4, 2, 4 * ((s == 0) ? 4 : 2 * s));
        end
        for (k = 0; k < 3; k++) begin
            s = $unsigned($random(seed)) % 3;
            h = $unsigned($random(seed)) % 4 + 1;
            wr(OFF_INT0, (h << 16) | s, RESP_OKAY);
            per(0, 1, (4 + s) * 2 * h);
        end
        wr(OFF_INT0 + 8'h4, 32'h2, RESP_OKAY);
        per(1, 1, 6);
        per(3, 1, 8);
        wr(OFF_FRAC_N0, 32'h3, RESP_OKAY);
        per(2, 1, 6);
        wr(OFF_FRAC_F0, 32'h800_0000, RESP_OKAY);
        per(2, 2, 12);
        wr(OFF_FRAC_N0, 32'h4, RESP_OKAY);
        per(2, 2, 18);
        $display("divider test done");
        // hitless then slope limited, loopback clear, one clock domain
        wr(OFF_CTRL, 32'h10, RESP_OKAY);
        active_ref <= 1'b1;
        evt(1, 0);
        holdover_active <= 1'b1;
        evt(1, 0);
        wr(OFF_CTRL, 32'h40, RESP_OKAY);
        active_ref <= 1'b0;
        evt(0, 1);
        phase_settled <= 1'b1;
        repeat (16) @(posedge aclk);
        `CHK(slew_active, 1'b0)
        $display("phase test done");
        summarize();
    end
endmodule : testbench
